// ---- bench/aag_core_chk.sv ----
// Checker for the add group core; it sees only the core's ports.
// Assumes one clock and the synchronous active-low reset rstn.
`default_nettype none

module aag_core_chk (
  input wire logic             clock,
  input wire logic             rstn,
  input wire logic             start,
  input wire aag_pkg::aag_op_e op,
  input wire logic [15:0]      dataWord,
  input wire aag_pkg::aag_loc_e operandLoc,
  input wire logic             codeExt,
  input wire logic             repeatPrefix,
  input wire logic             saturateEnable,
  input wire logic             busy,
  input wire logic             done,
  input wire logic             refused,
  input wire logic [31:0]      mainSumRegister,
  input wire logic [31:0]      sumBackupRegister,
  input wire logic             carryFlag,
  input wire logic [15:0]      pcStep,
  input wire logic [15:0]      cyclesUsed
);
  timeunit 1ns;
  timeprecision 1ps;
  // A take is an idle start the core may not refuse; plain ones cannot saturate.
  logic imm;
  logic take;
  logic plain;
  assign imm = op == aag_pkg::OP_SHORT_IMM || op == aag_pkg::OP_LONG_IMM;
  assign take = start && !busy && !done && !(repeatPrefix && imm);
  assign plain = take && !repeatPrefix && !saturateEnable;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  AST_IMM_REFUSED:
    assert property (start && !busy && !done && repeatPrefix && imm |=> refused && !done
      && $stable(mainSumRegister)) else $error("repeated immediate not refused");
  AST_PC_STEP:
    assert property (take |=> pcStep == (($past(op) == aag_pkg::OP_LONG_IMM) ? 16'h2 : 16'h1))
      else $error("program step wrong");
  AST_BUF_SUM:
    assert property (plain && op == aag_pkg::OP_BUFFER_SUM |=> $stable(sumBackupRegister) &&
      {carryFlag, mainSumRegister} == {1'h0, $past(mainSumRegister)} + $past(sumBackupRegister))
      else $error("buffer add wrong");
  AST_CARRY_SUM:
    assert property (plain && op == aag_pkg::OP_CARRY_IN |=> {carryFlag, mainSumRegister} ==
      {1'h0, $past(mainSumRegister)} + $past(dataWord) + $past(carryFlag))
      else $error("carry-in add wrong");
  AST_UNSIGNED_SUM:
    assert property (plain && op == aag_pkg::OP_UNSIGNED |=> {carryFlag, mainSumRegister} ==
      {1'h0, $past(mainSumRegister)} + $past(dataWord)) else $error("unsigned add wrong");
  AST_SHORT_SUM:
    assert property (plain && op == aag_pkg::OP_SHORT_IMM |=> {carryFlag, mainSumRegister} ==
      {1'h0, $past(mainSumRegister)} + ($past(dataWord) & 16'hFF)) else $error("short add wrong");
  AST_COST_ONE:
    assert property (take && !repeatPrefix && !codeExt && operandLoc == aag_pkg::LOC_DUAL &&
      op != aag_pkg::OP_LONG_IMM |=> done && cyclesUsed == 16'h1) else $error("not one cycle");
  AST_COST_LONG:
    assert property (take && !codeExt && op == aag_pkg::OP_LONG_IMM |=> !done ##1 done &&
      cyclesUsed == 16'h2) else $error("long immediate not two cycles");
endmodule // aag_core_chk

bind aag_core aag_core_chk aag_core_chk_inst (
  .clock(clock), .rstn(rstn), .start(start), .op(op), .dataWord(dataWord),
  .operandLoc(operandLoc), .codeExt(codeExt), .repeatPrefix(repeatPrefix),
  .saturateEnable(saturateEnable), .busy(busy), .done(done), .refused(refused),
  .mainSumRegister(mainSumRegister), .sumBackupRegister(sumBackupRegister),
  .carryFlag(carryFlag), .pcStep(pcStep), .cyclesUsed(cyclesUsed));

`default_nettype wire

// ---- bench/aag_mem_model.sv ----
// Data memory model that hands the core its operand word from a 7-bit offset.
// Assumes the bench stores each word with put before it raises start.
`default_nettype none

module aag_mem_model (
  input  wire logic [6:0]  addr,
  output logic      [15:0] rdData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [128];

  // Stores one word; the offset spans the whole direct range.
  task automatic put(input logic [6:0] a, input logic [15:0] w);
    mem[a] = w;
  endtask

  // Read is combinational, so the word has settled before start is sampled.
  assign rdData = mem[addr];
endmodule // aag_mem_model

`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench for the add group core: sums, flags and cycle costs.
// Assumes the package, core, checker and memory model are compiled first.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clock = 1'h0;
  logic              rstn = 1'h0;
  logic              start = 1'h0;
  aag_pkg::aag_op_e  op = aag_pkg::OP_GENERAL_MEM;
  aag_pkg::aag_loc_e operandLoc = aag_pkg::LOC_DUAL;
  logic [6:0]        memAddr = 7'h0;
  logic [4:0]        shiftCount = 5'h0;
  logic              codeExt = 1'h0;
  logic              sameBlock = 1'h0;
  logic              repeatPrefix = 1'h0;
  logic              signExtendEnable = 1'h0;
  logic              saturateEnable = 1'h0;
  logic              loadAcc = 1'h0;
  logic [15:0]       repeatCount = 16'h0;
  logic [3:0]        progWait = 4'h0;
  logic [3:0]        dataWait = 4'h0;
  logic [31:0]       loadAccValue = 32'h0;
  logic [31:0]       loadBackupValue = 32'h0;
  logic [31:0]       accE = 32'h0;
  logic [31:0]       bakE = 32'h0;
  logic              carryE = 1'h0;
  int                fails = 0;
  int                numChecks = 0;
  wire logic [15:0]  dataWord;
  wire logic         busy, done, refused, carryFlag, overflowFlag;
  wire logic [31:0]  mainSumRegister, sumBackupRegister;
  wire logic [15:0]  pcStep, cyclesUsed;

  aag_mem_model aag_mem_model_inst (.addr(memAddr), .rdData(dataWord));
  // Both direct loads share one strobe, which keeps that input live.
  aag_core aag_core_inst (
    .clock(clock), .rstn(rstn), .start(start), .op(op), .dataWord(dataWord),
    .shiftCount(shiftCount), .operandLoc(operandLoc), .codeExt(codeExt),
    .sameBlock(sameBlock), .repeatPrefix(repeatPrefix), .repeatCount(repeatCount),
    .progWait(progWait), .dataWait(dataWait), .signExtendEnable(signExtendEnable),
    .saturateEnable(saturateEnable), .loadAcc(loadAcc), .loadAccValue(loadAccValue),
    .loadBackup(loadAcc), .loadBackupValue(loadBackupValue), .busy(busy), .done(done),
    .refused(refused), .mainSumRegister(mainSumRegister),
    .sumBackupRegister(sumBackupRegister), .carryFlag(carryFlag),
    .overflowFlag(overflowFlag), .pcStep(pcStep), .cyclesUsed(cyclesUsed));

  // Free-running 100 MHz clock.
  always #5 clock = ~clock;

  // Compares one value; case inequality keeps unknowns from passing.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", numChecks, fails);
    if (fails == 0 && numChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Loads accumulator and backup together at the next edge.
  task automatic load(input logic [31:0] a, input logic [31:0] b);
    loadAcc = 1'h1;
    loadAccValue = a;
    loadBackupValue = b;
    @(negedge clock);
    loadAcc = 1'h0;
    accE = a;
    bakE = b;
  endtask

  // Issues one add, counts edges to done and checks every result except the overflow flag.
  task automatic doAdd(input aag_pkg::aag_op_e o, input logic [15:0] w,
                       input logic [4:0] s, input logic [15:0] ec);
    logic [31:0] opnd;
    logic [32:0] sum;
    int          cnt;
    opnd = {16'h0, w};
    if (o == aag_pkg::OP_GENERAL_MEM || o == aag_pkg::OP_LONG_IMM) begin
      opnd = (signExtendEnable ? {{16{w[15]}}, w} : {16'h0, w}) << s;
    end
    if (o == aag_pkg::OP_SHORT_IMM) begin
      opnd = {24'h0, w[7:0]};
    end
    if (o == aag_pkg::OP_BUFFER_SUM) begin
      opnd = bakE;
    end
    sum = {1'h0, accE} + opnd + ((o == aag_pkg::OP_CARRY_IN) ? carryE : 1'h0);
    if (saturateEnable && accE[31] == opnd[31] && sum[31] != accE[31]) begin
      sum[31:0] = accE[31] ? aag_pkg::SAT_NEG : aag_pkg::SAT_POS;
    end
    accE = sum[31:0];
    carryE = sum[32];
    memAddr++;
    aag_mem_model_inst.put(memAddr, w);
    op = o;
    shiftCount = s;
    start = 1'h1;
    @(negedge clock);
    start = 1'h0;
    cnt = 1;
    chk(busy, 32'h1);
    while (done !== 1'h1 && cnt < 200) begin
      @(negedge clock);
      cnt++;
    end
    chk(cnt, ec);
    chk(cyclesUsed, ec);
    chk(mainSumRegister, accE);
    chk(carryFlag, carryE);
    chk(sumBackupRegister, bakE);
    chk(pcStep, (o == aag_pkg::OP_LONG_IMM) ? 32'h2 : 32'h1);
    @(negedge clock);
    chk(busy, 32'h0);
    chk(done, 32'h0);
  endtask

  // Runs the three memory-operand adds with one placement and wait setting.
  task automatic costRow(input aag_pkg::aag_loc_e l, input logic cx, sb, rp,
                         input logic [15:0] n, input logic [3:0] p, d, input logic [15:0] ec);
    operandLoc = l;
    codeExt = cx;
    sameBlock = sb;
    repeatPrefix = rp;
    repeatCount = n;
    progWait = p;
    dataWait = d;
    doAdd(aag_pkg::OP_GENERAL_MEM, 16'h0, 5'h0, ec);
    doAdd(aag_pkg::OP_CARRY_IN, 16'h0, 5'h0, ec);
    doAdd(aag_pkg::OP_UNSIGNED, 16'h0, 5'h0, ec);
  endtask

  // Watchdog; the tests need only a few hundred cycles.
  initial begin
    #200000;
    fails++;
    report_and_stop();
  end

  // Main sequence of scenarios.
  initial begin
    repeat (5) @(negedge clock);
    rstn = 1'h1;
    chk(overflowFlag, 32'h0);
    load(32'h2, 32'h2);
    doAdd(aag_pkg::OP_GENERAL_MEM, 16'h1, 5'h1, 16'h1);
    signExtendEnable = 1'h1;
    doAdd(aag_pkg::OP_SHORT_IMM, 16'hFF80, 5'h0, 16'h1);
    doAdd(aag_pkg::OP_LONG_IMM, 16'h1111, 5'h1, 16'h2);
    doAdd(aag_pkg::OP_GENERAL_MEM, 16'h8000, 5'h10, 16'h1);
    load(32'h1234, 32'h2);
    doAdd(aag_pkg::OP_BUFFER_SUM, 16'h0, 5'h0, 16'h1);
    load(32'hFFFFFFFF, 32'h2);
    doAdd(aag_pkg::OP_GENERAL_MEM, 16'h1, 5'h0, 16'h1);
    doAdd(aag_pkg::OP_CARRY_IN, 16'h8004, 5'h0, 16'h1);
    load(32'h7FFF0000, 32'h0);
    doAdd(aag_pkg::OP_UNSIGNED, 16'hFFFF, 5'h0, 16'h1);
    signExtendEnable = 1'h0;
    chk(overflowFlag, 32'h0);
    doAdd(aag_pkg::OP_GENERAL_MEM, 16'hFFFF, 5'h0, 16'h1);
    chk(overflowFlag, 32'h1);
    // A repeated immediate form must be turned away without touching the sum.
    repeatPrefix = 1'h1;
    for (int i = 1; i < 3; i++) begin
      op = aag_pkg::aag_op_e'(i);
      start = 1'h1;
      @(negedge clock);
      start = 1'h0;
      chk(refused, 32'h1);
      @(negedge clock);
      chk(mainSumRegister, accE);
    end
    costRow(aag_pkg::LOC_SINGLE, 1'h0, 1'h1, 1'h0, 16'h0, 4'h0, 4'h0, 16'h2);
    costRow(aag_pkg::LOC_EXT, 1'h0, 1'h0, 1'h0, 16'h0, 4'h0, 4'h2, 16'h3);
    costRow(aag_pkg::LOC_EXT, 1'h1, 1'h0, 1'h0, 16'h0, 4'h3, 4'h2, 16'h7);
    costRow(aag_pkg::LOC_DUAL, 1'h0, 1'h0, 1'h1, 16'h4, 4'h0, 4'h0, 16'h4);
    costRow(aag_pkg::LOC_SINGLE, 1'h0, 1'h1, 1'h1, 16'h4, 4'h0, 4'h0, 16'h5);
    costRow(aag_pkg::LOC_DUAL, 1'h1, 1'h0, 1'h1, 16'h4, 4'h3, 4'h0, 16'h7);
    costRow(aag_pkg::LOC_EXT, 1'h0, 1'h0, 1'h1, 16'h4, 4'h0, 4'h2, 16'hC);
    costRow(aag_pkg::LOC_EXT, 1'h1, 1'h0, 1'h1, 16'h4, 4'h3, 4'h2, 16'h10);
    costRow(aag_pkg::LOC_DUAL, 1'h1, 1'h0, 1'h0, 16'h0, 4'h3, 4'h0, 16'h4);
    doAdd(aag_pkg::OP_SHORT_IMM, 16'h1, 5'h0, 16'h4);
    doAdd(aag_pkg::OP_LONG_IMM, 16'h1, 5'h0, 16'h8);
    doAdd(aag_pkg::OP_BUFFER_SUM, 16'h0, 5'h0, 16'h4);
    // A mid-run reset clears the sum, the flags and the sticky overflow flag,
    // so the saturation check below cannot pass on a stale flag.
    rstn = 1'h0;
    @(negedge clock);
    rstn = 1'h1;
    carryE = 1'h0;
    chk(overflowFlag, 32'h0);
    chk(mainSumRegister, 32'h0);
    chk(carryFlag, 32'h0);
    chk(cyclesUsed, 32'h0);
    chk(pcStep, 32'h0);
    codeExt = 1'h0;
    progWait = 4'h0;
    saturateEnable = 1'h1;
    load(32'h7FFFFFFF, 32'h0);
    doAdd(aag_pkg::OP_GENERAL_MEM, 16'h1, 5'h0, 16'h1);
    chk(overflowFlag, 32'h1);
    report_and_stop();
  end
endmodule // testbench

`default_nettype wire

// ---- src/aag_core.sv ----
// Accumulator add group execution datapath.
// Assumes the decoder gives a one-cycle start with operands held stable,
// and that the data word is already fetched when start is raised.
`default_nettype none

module aag_core (
  input  wire logic                          clock,
  input  wire logic                          rstn,
  input  wire logic                          start,
  input  wire aag_pkg::aag_op_e              op,
  input  wire logic [aag_pkg::DATA_W-1:0]    dataWord,
  input  wire logic [aag_pkg::SHIFT_W-1:0]   shiftCount,
  input  wire aag_pkg::aag_loc_e             operandLoc,
  input  wire logic                          codeExt,
  input  wire logic                          sameBlock,
  input  wire logic                          repeatPrefix,
  input  wire logic [aag_pkg::CNT_W-1:0]     repeatCount,
  input  wire logic [aag_pkg::WAIT_W-1:0]    progWait,
  input  wire logic [aag_pkg::WAIT_W-1:0]    dataWait,
  input  wire logic                          signExtendEnable,
  input  wire logic                          saturateEnable,
  input  wire logic                          loadAcc,
  input  wire logic [aag_pkg::ACC_W-1:0]     loadAccValue,
  input  wire logic                          loadBackup,
  input  wire logic [aag_pkg::ACC_W-1:0]     loadBackupValue,
  output logic                               busy,
  output logic                               done,
  output logic                               refused,
  output logic [aag_pkg::ACC_W-1:0]          mainSumRegister,
  output logic [aag_pkg::ACC_W-1:0]          sumBackupRegister,
  output logic                               carryFlag,
  output logic                               overflowFlag,
  output logic [aag_pkg::PC_W-1:0]           pcStep,
  output logic [aag_pkg::CNT_W-1:0]          cyclesUsed
);

  timeunit 1ns;
  timeprecision 1ps;

  localparam int AW = aag_pkg::ACC_W;
  localparam int CW = aag_pkg::CNT_W;

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  aag_pkg::aag_state_e state_r;
  logic [AW-1:0]       acc_r;
  logic [AW-1:0]       backup_r;
  logic                carry_r;
  logic                ovf_r;
  logic [CW-1:0]       left_r;
  logic [CW-1:0]       total_r;
  logic                busy_r;
  logic                done_r;
  logic                refused_r;
  logic [aag_pkg::PC_W-1:0] pcStep_r;
  aag_cost_if          costBus ();

  // ----------------------------------------------------------------------------
  // Cost request and calculator
  // ----------------------------------------------------------------------------
  assign costBus.op = op;
  assign costBus.operandLoc = operandLoc;
  assign costBus.codeExt = codeExt;
  assign costBus.sameBlock = sameBlock;
  assign costBus.repeatOn = repeatPrefix;
  assign costBus.repeatCount = repeatCount;
  assign costBus.progWait = progWait;
  assign costBus.dataWait = dataWait;

  aag_cost_calc costCalc (
    .cost (costBus.calc)
  );

  // A repeated immediate form is refused outright rather than run once.
  logic immOp;
  logic refuse;
  logic accept;
  assign immOp = (op == aag_pkg::OP_SHORT_IMM) || (op == aag_pkg::OP_LONG_IMM);
  assign refuse = start && (state_r == aag_pkg::ST_IDLE) && repeatPrefix && immOp;
  assign accept = start && (state_r == aag_pkg::ST_IDLE) && !refuse;

  // ----------------------------------------------------------------------------
  // Addend and sum
  // ----------------------------------------------------------------------------
  // The sum is computed one bit wider so the carry out falls out directly.
  logic [AW-1:0] addend;
  logic          carryIn;
  logic [AW:0]   sumWide;
  logic          ovfDet;
  logic          useShift;
  logic [4:0]    shiftEff;
  always_comb begin
    addend = '0;
    carryIn = 1'b0;
    useShift = 1'b0;
    shiftEff = (shiftCount > aag_pkg::SHIFT_MAX) ? aag_pkg::SHIFT_MAX : shiftCount;
    unique case (op)
      aag_pkg::OP_GENERAL_MEM, aag_pkg::OP_LONG_IMM: begin
        useShift = 1'b1;
        addend = signExtendEnable ? AW'($signed(dataWord))
                                  : AW'(dataWord);
      end
      aag_pkg::OP_SHORT_IMM: begin
        addend = AW'(dataWord[7:0]);
      end
      aag_pkg::OP_BUFFER_SUM: begin
        addend = backup_r;
      end
      aag_pkg::OP_CARRY_IN: begin
        addend = AW'(dataWord);
        carryIn = carry_r;
      end
      aag_pkg::OP_UNSIGNED: begin
        addend = AW'(dataWord);
      end
      default: begin
        addend = '0;
      end
    endcase
    if (useShift) begin
      addend = AW'(addend << shiftEff);
    end
    sumWide = (AW+1)'({1'b0, acc_r} + {1'b0, addend} + (AW+1)'(carryIn));
    ovfDet = (acc_r[AW-1] == addend[AW-1]) && (sumWide[AW-1] != acc_r[AW-1]);
  end

  // ----------------------------------------------------------------------------
  // Sequencer: counts out the cycle cost of each accepted add
  // ----------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_r <= aag_pkg::ST_IDLE;
      left_r <= '0;
      total_r <= '0;
    end else begin
      unique case (state_r)
        aag_pkg::ST_IDLE: begin
          if (accept) begin
            total_r <= costBus.cycles;
            left_r <= CW'(costBus.cycles - aag_pkg::CYC_ONE);
            state_r <= (costBus.cycles > aag_pkg::CYC_ONE) ? aag_pkg::ST_WAIT
                                                           : aag_pkg::ST_DONE;
          end
        end
        aag_pkg::ST_WAIT: begin
          left_r <= CW'(left_r - aag_pkg::CYC_ONE);
          if (left_r == aag_pkg::CYC_ONE) begin
            state_r <= aag_pkg::ST_DONE;
          end
        end
        aag_pkg::ST_DONE: begin
          state_r <= aag_pkg::ST_IDLE;
        end
        default: begin
          state_r <= aag_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Accumulator, carry and overflow update at acceptance
  // ----------------------------------------------------------------------------
  // The result is written once at acceptance; the wait states only hold off done.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      acc_r <= aag_pkg::ACC_RESET;
      carry_r <= 1'b0;
      ovf_r <= 1'b0;
    end else if (accept) begin
      carry_r <= sumWide[AW];
      if (ovfDet) begin
        ovf_r <= 1'b1;
      end
      if (ovfDet && saturateEnable) begin
        acc_r <= acc_r[AW-1] ? aag_pkg::SAT_NEG : aag_pkg::SAT_POS;
      end else begin
        acc_r <= sumWide[AW-1:0];
      end
    end else if (loadAcc) begin
      acc_r <= loadAccValue;
    end
  end

  // The backup register is only loaded from outside, never by an add.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      backup_r <= aag_pkg::ACC_RESET;
    end else if (loadBackup) begin
      backup_r <= loadBackupValue;
    end
  end

  // ----------------------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      refused_r <= 1'b0;
      pcStep_r <= '0;
    end else begin
      busy_r <= accept || (state_r == aag_pkg::ST_WAIT && left_r != aag_pkg::CYC_ONE);
      done_r <= (state_r == aag_pkg::ST_WAIT && left_r == aag_pkg::CYC_ONE)
             || (accept && costBus.cycles <= aag_pkg::CYC_ONE);
      refused_r <= refuse;
      if (accept) begin
        pcStep_r <= (op == aag_pkg::OP_LONG_IMM) ? aag_pkg::PC_STEP_TWO
                                                 : aag_pkg::PC_STEP_ONE;
      end
    end
  end

  assign busy = busy_r;
  assign done = done_r;
  assign refused = refused_r;
  assign mainSumRegister = acc_r;
  assign sumBackupRegister = backup_r;
  assign carryFlag = carry_r;
  assign overflowFlag = ovf_r;
  assign pcStep = pcStep_r;
  assign cyclesUsed = total_r;

endmodule : aag_core

`default_nettype wire

// ---- src/aag_cost_calc.sv ----
// Cycle cost calculator for one add instruction.
// Assumes the caller holds the request steady while it reads the answer.
`default_nettype none

module aag_cost_calc (
  aag_cost_if.calc cost
);

  timeunit 1ns;
  timeprecision 1ps;

  localparam int CW = aag_pkg::CNT_W;

  // ----------------------------------------------------------------------------
  // Cost from operand place, code place and repeat count
  // ----------------------------------------------------------------------------
  // The memory forms share one table, so the three memory ops give equal cost.
  always_comb begin
    logic [CW-1:0] n;
    logic [CW-1:0] p;
    logic [CW-1:0] d;
    logic          memOp;
    n = cost.repeatOn ? cost.repeatCount : aag_pkg::CYC_ONE;
    p = CW'(cost.progWait);
    d = CW'(cost.dataWait);
    memOp = (cost.op == aag_pkg::OP_GENERAL_MEM) || (cost.op == aag_pkg::OP_CARRY_IN)
         || (cost.op == aag_pkg::OP_UNSIGNED);
    cost.cycles = n;
    if (cost.op == aag_pkg::OP_SHORT_IMM) begin
      cost.cycles = CW'(aag_pkg::CYC_ONE + (cost.codeExt ? p : '0));
    end else if (cost.op == aag_pkg::OP_LONG_IMM) begin
      cost.cycles = CW'(aag_pkg::CYC_TWO + (cost.codeExt ? CW'(p << 1) : '0));
    end else if (memOp && cost.operandLoc == aag_pkg::LOC_EXT) begin
      cost.cycles = CW'(n + n * d);
      if (cost.codeExt) begin
        cost.cycles = CW'(cost.cycles + aag_pkg::CYC_ONE + p);
      end
    end else begin
      cost.cycles = CW'(n + (cost.codeExt ? p : '0));
      if (memOp && cost.operandLoc == aag_pkg::LOC_SINGLE && cost.sameBlock
          && !cost.codeExt) begin
        cost.cycles = CW'(cost.cycles + aag_pkg::CYC_ONE);
      end
    end
  end

endmodule : aag_cost_calc

`default_nettype wire

// ---- src/aag_cost_if.sv ----
// Interface carrying the cycle-cost request and answer between the core
// and its cost calculator. The calculator is combinational; only the core is clocked.
`default_nettype none

interface aag_cost_if;
  timeunit 1ns;
  timeprecision 1ps;
  aag_pkg::aag_op_e  op;
  aag_pkg::aag_loc_e operandLoc;
  logic                           codeExt;
  logic                           sameBlock;
  logic                           repeatOn;
  logic [aag_pkg::CNT_W-1:0]      repeatCount;
  logic [aag_pkg::WAIT_W-1:0]     progWait;
  logic [aag_pkg::WAIT_W-1:0]     dataWait;
  logic [aag_pkg::CNT_W-1:0]      cycles;

  modport core (output op, operandLoc, codeExt, sameBlock, repeatOn, repeatCount,
                output progWait, dataWait, input cycles);
  modport calc (input op, operandLoc, codeExt, sameBlock, repeatOn, repeatCount,
                input progWait, dataWait, output cycles);
endinterface : aag_cost_if

`default_nettype wire

// ---- src/aag_pkg.sv ----
// Package of constants and types for the accumulator add group datapath.
// Assumes one core clock and a decoder that presents one add request at a time.
`default_nettype none

package aag_pkg;
  timeunit 1ns;
  timeprecision 1ps;

  // --------------------------------------------------------------------------
  // Widths and constants
  // --------------------------------------------------------------------------
  localparam int ACC_W = 32;
  localparam int DATA_W = 16;
  localparam int SHIFT_W = 5;
  localparam int WAIT_W = 4;
  localparam int CNT_W = 16;
  localparam int PC_W = 16;
  localparam logic [4:0] SHIFT_MAX = 5'h10;
  localparam logic [PC_W-1:0] PC_STEP_ONE = 16'h0001;
  localparam logic [PC_W-1:0] PC_STEP_TWO = 16'h0002;
  localparam logic [CNT_W-1:0] CYC_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] CYC_TWO = 16'h0002;
  localparam logic [ACC_W-1:0] SAT_POS = 32'h7FFFFFFF;
  localparam logic [ACC_W-1:0] SAT_NEG = 32'h80000000;
  localparam logic [ACC_W-1:0] ACC_RESET = 32'h00000000;

  // --------------------------------------------------------------------------
  // Operation and operand-place codes
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_GENERAL_MEM = 3'h0,  // Direct or indirect add with shift.
    OP_SHORT_IMM   = 3'h1,
    OP_LONG_IMM    = 3'h2,
    OP_BUFFER_SUM  = 3'h3,  // buffer_sum_op
    OP_CARRY_IN    = 3'h4,  // carry_in_sum_op
    OP_UNSIGNED    = 3'h5   // unsigned_sum_op
  } aag_op_e;

  typedef enum logic [1:0] {
    LOC_DUAL   = 2'h0,  // dual_port_ram or program ROM
    LOC_SINGLE = 2'h1,  // single_port_ram
    LOC_EXT    = 2'h2
  } aag_loc_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1,
    ST_DONE = 2'h2
  } aag_state_e;

endpackage : aag_pkg

`default_nettype wire
